// *** common/tpcr_pkg.sv ***
// package: register map, field layout and carrier structs for the phy control bank
package tpcr_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;
    localparam int NUM_CH = 4;
    localparam int CH_W = 8;
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_VERSION = 9'h000;
    localparam logic [ADDR_W-1:0] OFS_BANK = 9'h00C;
    localparam logic [ADDR_W-1:0] OFS_REFCLK = 9'h010;
    localparam logic [ADDR_W-1:0] OFS_PLLRST = 9'h014;
    localparam logic [ADDR_W-1:0] OFS_PLLLOCK = 9'h018;
    localparam logic [ADDR_W-1:0] OFS_TXINIT = 9'h01C;
    localparam logic [ADDR_W-1:0] OFS_TXSTAT = 9'h020;
    localparam logic [ADDR_W-1:0] OFS_RXINIT = 9'h024;
    localparam logic [ADDR_W-1:0] OFS_RXSTAT = 9'h028;
    localparam logic [ADDR_W-1:0] OFS_BUFCTRL = 9'h02C;
    localparam logic [ADDR_W-1:0] OFS_PWRDN = 9'h030;
    localparam logic [ADDR_W-1:0] OFS_LOOP = 9'h038;
    // writable bit masks, reserved bits stay zero
    localparam logic [DATA_W-1:0] MSK_BANK = 32'h0000_1F1F;
    localparam logic [DATA_W-1:0] MSK_REFCLK = 32'hFF00_0FFF;
    localparam logic [DATA_W-1:0] MSK_PLLRST = 32'h0000_0007;
    localparam logic [DATA_W-1:0] MSK_TXINIT = 32'h8F8F_8F8F;
    localparam logic [DATA_W-1:0] MSK_RXINIT = 32'hFFFF_FFFF;
    localparam logic [DATA_W-1:0] MSK_BUFCTRL = 32'h0000_0003;
    localparam logic [DATA_W-1:0] MSK_PWRDN = 32'h7F7F_7F7F;
    localparam logic [DATA_W-1:0] MSK_LOOP = 32'h0707_0707;
    localparam logic [DATA_W-1:0] RST_ZERO = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    // field positions
    localparam int F_QPLL0_REF = 0;
    localparam int F_CPLL_REF = 4;
    localparam int F_QPLL1_REF = 8;
    localparam int F_RX_SYSCLK = 24;
    localparam int F_TX_SYSCLK = 26;
    localparam int F_RX_PLLCLK = 28;
    localparam int F_TX_PLLCLK = 30;
    localparam int F_TX_BANK = 0;
    localparam int F_RX_BANK = 8;
    localparam int B_CPLL_RST = 0;
    localparam int B_QPLL0_RST = 1;
    localparam int B_QPLL1_RST = 2;
    localparam int B_QPLL0_LOCK = 4;
    localparam int B_QPLL1_LOCK = 5;
    localparam int B_XRST = 0;
    localparam int B_ARST = 1;
    localparam int B_TX_CRST = 2;
    localparam int B_TX_URDY = 3;
    localparam int B_RX_EQRST = 2;
    localparam int B_RX_EYRST = 3;
    localparam int B_RX_CRST = 4;
    localparam int B_RX_BRST = 5;
    localparam int B_RX_URDY = 6;
    localparam int B_PLLXRST = 7;
    localparam int B_DONE = 0;
    localparam int B_ADONE = 1;
    localparam int B_PWROK = 2;
    localparam int F_RX_POWER_DOWN = 3;
    localparam int F_TX_POWER_DOWN = 5;
    localparam int B_LINK_RDY = 0;
    localparam int B_VID_RDY = 1;

    // per channel transmit controls
    typedef struct packed {
        logic xcvr_tx_reset;
        logic tx_analog_reset;
        logic tx_coding_reset;
        logic tx_user_ready;
        logic pll_and_xcvr_reset;
    } tpcr_tx_ctl_s;
    // per channel receive controls
    typedef struct packed {
        logic xcvr_rx_reset;
        logic rx_analog_reset;
        logic rx_equalizer_reset;
        logic eye_scan_reset_a;
        logic rx_coding_reset;
        logic rx_buffer_reset;
        logic rx_user_ready;
        logic pll_and_xcvr_reset;
    } tpcr_rx_ctl_s;
    // per channel power down controls
    typedef struct packed {
        logic chan_pll_power_down;
        logic quad_pll0_power_down;
        logic quad_pll1_power_down;
        logic [1:0] rx_power_down;
        logic [1:0] tx_power_down;
    } tpcr_pd_s;
    // clock selection
    typedef struct packed {
        logic [3:0] quad_pll0_ref_select;
        logic [3:0] chan_pll_ref_select;
        logic [3:0] quad_pll1_ref_select;
        logic [1:0] tx_system_clock_select;
        logic [1:0] rx_system_clock_select;
        logic [1:0] tx_pll_clock_select;
        logic [1:0] rx_pll_clock_select;
    } tpcr_clk_s;
    // status per channel from the transceivers
    typedef struct packed {
        logic reset_done;
        logic analog_reset_complete;
        logic xcvr_power_ok;
    } tpcr_stat_s;
    // axi4-lite request side
    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic [2:0] awprot;
        logic awvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic [2:0] arprot;
        logic arvalid;
        logic rready;
    } tpcr_axi_req_s;
    // axi4-lite response side
    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } tpcr_axi_rsp_s;
endpackage

// *** hdl/tpcr_regs.sv ***
// transceiver phy control and status register bank on axi4-lite
`timescale 1ns/100ps
module tpcr_regs #(
    parameter logic [31:0] VERSION_WORD = 32'h0A0B_0C0D // arbitrary value
) (
    input wire logic ref_clk, // axi4-lite clock
    input wire logic nrst, // synchronous reset, active low
    input wire tpcr_pkg::tpcr_axi_req_s axi_req, // axi4-lite request
    output tpcr_pkg::tpcr_axi_rsp_s axi_rsp, // axi4-lite response
    output logic [4:0] tx_bank, // transmit bank number
    output logic [4:0] rx_bank, // receive bank number
    output tpcr_pkg::tpcr_clk_s clk_sel, // clock selects
    output logic chan_pll_reset, // channel pll reset
    output logic quad_pll0_reset, // quad pll0 reset
    output logic quad_pll1_reset, // quad pll1 reset
    input wire logic [3:0] chan_pll_locked, // channel pll locks
    input wire logic quad_pll0_locked, // quad pll0 lock
    input wire logic quad_pll1_locked, // quad pll1 lock
    output tpcr_pkg::tpcr_tx_ctl_s [3:0] tx_ctl, // transmit init controls
    output tpcr_pkg::tpcr_rx_ctl_s [3:0] rx_ctl, // receive init controls
    input wire tpcr_pkg::tpcr_stat_s [3:0] tx_stat, // transmit init status
    input wire tpcr_pkg::tpcr_stat_s [3:0] rx_stat, // receive init status
    output logic refclk0_buffer_disable, // reference buffer 0 disable
    output logic refclk1_buffer_disable, // reference buffer 1 disable
    output tpcr_pkg::tpcr_pd_s [3:0] pwr_dn, // power down controls
    output logic [3:0][2:0] loopback_mode, // loopback code per channel
    input wire logic rx_video_clk_stable, // rx clock manager stable
    output logic [1:0] rx_status_sb_tdata, // rx status sideband data
    output logic rx_status_sb_tvalid, // rx status sideband valid
    input wire logic rx_status_sb_tready // rx status sideband ready
);
    import tpcr_pkg::*;

    // raw status bundle before synchronisation
    typedef struct packed {
        logic [3:0] cpll;
        logic q0;
        logic q1;
        tpcr_stat_s [3:0] tx;
        tpcr_stat_s [3:0] rx;
        logic vid;
    } tpcr_in_s;

    // whole module state
    typedef struct packed {
        logic [DATA_W-1:0] bank;
        logic [DATA_W-1:0] refclk;
        logic [DATA_W-1:0] pllrst;
        logic [DATA_W-1:0] txinit;
        logic [DATA_W-1:0] rxinit;
        logic [DATA_W-1:0] bufctrl;
        logic [DATA_W-1:0] pwrdn;
        logic [DATA_W-1:0] loopb;
        tpcr_in_s sync1;
        tpcr_in_s sync2;
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [DATA_W-1:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] sb;
    } tpcr_state_s;

    tpcr_state_s st;
    tpcr_state_s next_st;
    tpcr_in_s raw_in;
    logic [DATA_W-1:0] plllock_word;
    logic [DATA_W-1:0] txstat_word;
    logic [DATA_W-1:0] rxstat_word;
    logic [DATA_W-1:0] wr_mask;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [3:0] wr_strb;
    logic do_write;
    logic do_read;
    logic [DATA_W-1:0] rd_word;

    // gather raw transceiver status
    always_comb begin
        raw_in.cpll = chan_pll_locked;
        raw_in.q0 = quad_pll0_locked;
        raw_in.q1 = quad_pll1_locked;
        raw_in.tx = tx_stat;
        raw_in.rx = rx_stat;
        raw_in.vid = rx_video_clk_stable;
    end

    // status words built from synchronised inputs
    always_comb begin
        plllock_word = RST_ZERO;
        txstat_word = RST_ZERO;
        rxstat_word = RST_ZERO;
        plllock_word[NUM_CH-1:0] = st.sync2.cpll;
        plllock_word[B_QPLL0_LOCK] = st.sync2.q0;
        plllock_word[B_QPLL1_LOCK] = st.sync2.q1;
        for (int c = 0; c < NUM_CH; c++) begin
            txstat_word[c*CH_W+B_DONE] = st.sync2.tx[c].reset_done;
            txstat_word[c*CH_W+B_ADONE] = st.sync2.tx[c].analog_reset_complete;
            txstat_word[c*CH_W+B_PWROK] = st.sync2.tx[c].xcvr_power_ok;
            rxstat_word[c*CH_W+B_DONE] = st.sync2.rx[c].reset_done;
            rxstat_word[c*CH_W+B_ADONE] = st.sync2.rx[c].analog_reset_complete;
            rxstat_word[c*CH_W+B_PWROK] = st.sync2.rx[c].xcvr_power_ok;
        end
    end

    // write path: address and data may come in either order
    always_comb begin
        wr_addr = st.aw_held ? st.aw_addr : axi_req.awaddr;
        wr_data = st.w_held ? st.w_data : axi_req.wdata;
        wr_strb = st.w_held ? st.w_strb : axi_req.wstrb;
        do_write = (st.aw_held || axi_req.awvalid) && (st.w_held || axi_req.wvalid)
                   && !st.bvalid;
        do_read = axi_req.arvalid && !st.rvalid;
        for (int b = 0; b < 4; b++) begin
            wr_mask[b*8 +: 8] = {8{wr_strb[b]}};
        end
    end

    // read decode on offset only; unknown offsets read zero
    always_comb begin
        case (axi_req.araddr[ADDR_W-1:2])
            OFS_VERSION[ADDR_W-1:2]: rd_word = VERSION_WORD;
            OFS_BANK[ADDR_W-1:2]: rd_word = st.bank;
            OFS_REFCLK[ADDR_W-1:2]: rd_word = st.refclk;
            OFS_PLLRST[ADDR_W-1:2]: rd_word = st.pllrst;
            OFS_PLLLOCK[ADDR_W-1:2]: rd_word = plllock_word;
            OFS_TXINIT[ADDR_W-1:2]: rd_word = st.txinit;
            OFS_TXSTAT[ADDR_W-1:2]: rd_word = txstat_word;
            OFS_RXINIT[ADDR_W-1:2]: rd_word = st.rxinit;
            OFS_RXSTAT[ADDR_W-1:2]: rd_word = rxstat_word;
            OFS_BUFCTRL[ADDR_W-1:2]: rd_word = st.bufctrl;
            OFS_PWRDN[ADDR_W-1:2]: rd_word = st.pwrdn;
            OFS_LOOP[ADDR_W-1:2]: rd_word = st.loopb;
            default: rd_word = RST_ZERO;
        endcase
    end

    // next state
    always_comb begin
        next_st = st;
        next_st.sync1 = raw_in;
        next_st.sync2 = st.sync1;
        // capture halves of a write that arrive apart, only while ready is shown
        if (axi_req.awvalid && !st.aw_held && !st.bvalid && !do_write) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && !st.w_held && !st.bvalid && !do_write) begin
            next_st.w_held = 1'b1;
            next_st.w_data = axi_req.wdata;
            next_st.w_strb = axi_req.wstrb;
        end
        if (do_write) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            case (wr_addr[ADDR_W-1:2])
                OFS_BANK[ADDR_W-1:2]: next_st.bank = (st.bank & ~(wr_mask & MSK_BANK))
                    | (wr_data & wr_mask & MSK_BANK);
                OFS_REFCLK[ADDR_W-1:2]: next_st.refclk = (st.refclk & ~(wr_mask & MSK_REFCLK))
                    | (wr_data & wr_mask & MSK_REFCLK);
                OFS_PLLRST[ADDR_W-1:2]: next_st.pllrst = (st.pllrst & ~(wr_mask & MSK_PLLRST))
                    | (wr_data & wr_mask & MSK_PLLRST);
                OFS_TXINIT[ADDR_W-1:2]: next_st.txinit = (st.txinit & ~(wr_mask & MSK_TXINIT))
                    | (wr_data & wr_mask & MSK_TXINIT);
                OFS_RXINIT[ADDR_W-1:2]: next_st.rxinit = (st.rxinit & ~(wr_mask & MSK_RXINIT))
                    | (wr_data & wr_mask & MSK_RXINIT);
                OFS_BUFCTRL[ADDR_W-1:2]: next_st.bufctrl = (st.bufctrl & ~(wr_mask & MSK_BUFCTRL))
                    | (wr_data & wr_mask & MSK_BUFCTRL);
                OFS_PWRDN[ADDR_W-1:2]: next_st.pwrdn = (st.pwrdn & ~(wr_mask & MSK_PWRDN))
                    | (wr_data & wr_mask & MSK_PWRDN);
                OFS_LOOP[ADDR_W-1:2]: next_st.loopb = (st.loopb & ~(wr_mask & MSK_LOOP))
                    | (wr_data & wr_mask & MSK_LOOP);
                default: next_st.bvalid = 1'b1;
            endcase
        end else if (st.bvalid && axi_req.bready) begin
            next_st.bvalid = 1'b0;
        end
        // read response
        if (do_read) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = rd_word;
        end else if (st.rvalid && axi_req.rready) begin
            next_st.rvalid = 1'b0;
        end
        // receive sideband status on the bus clock
        next_st.sb[B_LINK_RDY] = st.sync2.rx[0].reset_done;
        next_st.sb[B_VID_RDY] = st.sync2.vid;
    end

    // state register with synchronous reset to zero
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // axi4-lite response outputs
    always_comb begin
        axi_rsp.awready = !st.aw_held && !st.bvalid;
        axi_rsp.wready = !st.w_held && !st.bvalid;
        axi_rsp.bresp = RESP_OKAY;
        axi_rsp.bvalid = st.bvalid;
        axi_rsp.arready = !st.rvalid;
        axi_rsp.rdata = st.rdata;
        axi_rsp.rresp = RESP_OKAY;
        axi_rsp.rvalid = st.rvalid;
    end

    // control fields out of the registers
    always_comb begin
        tx_bank = st.bank[F_TX_BANK +: 5];
        rx_bank = st.bank[F_RX_BANK +: 5];
        clk_sel.quad_pll0_ref_select = st.refclk[F_QPLL0_REF +: 4];
        clk_sel.chan_pll_ref_select = st.refclk[F_CPLL_REF +: 4];
        clk_sel.quad_pll1_ref_select = st.refclk[F_QPLL1_REF +: 4];
        clk_sel.tx_system_clock_select = st.refclk[F_TX_SYSCLK +: 2];
        clk_sel.rx_system_clock_select = st.refclk[F_RX_SYSCLK +: 2];
        clk_sel.tx_pll_clock_select = st.refclk[F_TX_PLLCLK +: 2];
        clk_sel.rx_pll_clock_select = st.refclk[F_RX_PLLCLK +: 2];
        chan_pll_reset = st.pllrst[B_CPLL_RST];
        quad_pll0_reset = st.pllrst[B_QPLL0_RST];
        quad_pll1_reset = st.pllrst[B_QPLL1_RST];
        refclk0_buffer_disable = st.bufctrl[0];
        refclk1_buffer_disable = st.bufctrl[1];
        for (int c = 0; c < NUM_CH; c++) begin
            tx_ctl[c].xcvr_tx_reset = st.txinit[c*CH_W+B_XRST];
            tx_ctl[c].tx_analog_reset = st.txinit[c*CH_W+B_ARST];
            tx_ctl[c].tx_coding_reset = st.txinit[c*CH_W+B_TX_CRST];
            tx_ctl[c].tx_user_ready = st.txinit[c*CH_W+B_TX_URDY];
            tx_ctl[c].pll_and_xcvr_reset = st.txinit[c*CH_W+B_PLLXRST];
            rx_ctl[c].xcvr_rx_reset = st.rxinit[c*CH_W+B_XRST];
            rx_ctl[c].rx_analog_reset = st.rxinit[c*CH_W+B_ARST];
            rx_ctl[c].rx_equalizer_reset = st.rxinit[c*CH_W+B_RX_EQRST];
            rx_ctl[c].eye_scan_reset_a = st.rxinit[c*CH_W+B_RX_EYRST];
            rx_ctl[c].rx_coding_reset = st.rxinit[c*CH_W+B_RX_CRST];
            rx_ctl[c].rx_buffer_reset = st.rxinit[c*CH_W+B_RX_BRST];
            rx_ctl[c].rx_user_ready = st.rxinit[c*CH_W+B_RX_URDY];
            rx_ctl[c].pll_and_xcvr_reset = st.rxinit[c*CH_W+B_PLLXRST];
            pwr_dn[c].chan_pll_power_down = st.pwrdn[c*CH_W+B_CPLL_RST];
            pwr_dn[c].quad_pll0_power_down = st.pwrdn[c*CH_W+B_QPLL0_RST];
            pwr_dn[c].quad_pll1_power_down = st.pwrdn[c*CH_W+B_QPLL1_RST];
            pwr_dn[c].rx_power_down = st.pwrdn[c*CH_W+F_RX_POWER_DOWN +: 2];
            pwr_dn[c].tx_power_down = st.pwrdn[c*CH_W+F_TX_POWER_DOWN +: 2];
            loopback_mode[c] = st.loopb[c*CH_W +: 3];
        end
        rx_status_sb_tdata = st.sb;
        rx_status_sb_tvalid = 1'b1;
    end
endmodule

// *** verification/test_tpcr_regs.sv ***
// self-checking bench for the phy control register bank
`timescale 1ns/100ps
module test_tpcr_regs;
    import tpcr_pkg::*;
    localparam logic [31:0] VER = 32'h3C5A_0917; // arbitrary value
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    tpcr_axi_req_s axi_req = '0;
    tpcr_axi_rsp_s axi_rsp;
    logic [4:0] tx_bank, rx_bank;
    tpcr_clk_s clk_sel;
    logic chan_pll_reset, quad_pll0_reset, quad_pll1_reset;
    logic [3:0] chan_pll_locked;
    logic quad_pll0_locked, quad_pll1_locked;
    tpcr_tx_ctl_s [3:0] tx_ctl;
    tpcr_rx_ctl_s [3:0] rx_ctl;
    tpcr_stat_s [3:0] tx_stat, rx_stat;
    logic refclk0_buffer_disable, refclk1_buffer_disable;
    tpcr_pd_s [3:0] pwr_dn;
    logic [3:0][2:0] loopback_mode;
    logic rx_video_clk_stable = 1'b0;
    logic [1:0] rx_status_sb_tdata;
    logic rx_status_sb_tvalid;
    logic rx_status_sb_tready = 1'b0;
    logic [3:0] power_ok = 4'h0;
    logic [31:0] sh [16];
    int err_count = 0;
    int check_count = 0;
    int seed = 18201;
    bit split = 1'b0;
    // clock
    always #50 ref_clk = ~ref_clk;
    tpcr_regs #(.VERSION_WORD(VER)) i_dut (.ref_clk, .nrst, .axi_req, .axi_rsp, .tx_bank,
        .rx_bank, .clk_sel, .chan_pll_reset, .quad_pll0_reset, .quad_pll1_reset,
        .chan_pll_locked, .quad_pll0_locked, .quad_pll1_locked, .tx_ctl, .rx_ctl, .tx_stat,
        .rx_stat, .refclk0_buffer_disable, .refclk1_buffer_disable, .pwr_dn, .loopback_mode,
        .rx_video_clk_stable, .rx_status_sb_tdata, .rx_status_sb_tvalid, .rx_status_sb_tready);
    tpcr_xcvr_model i_xcvr (.ref_clk, .chan_pll_reset, .quad_pll0_reset, .quad_pll1_reset,
        .tx_ctl, .rx_ctl, .pwr_dn, .power_ok, .chan_pll_locked, .quad_pll0_locked,
        .quad_pll1_locked, .tx_stat, .rx_stat);
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    function automatic logic [31:0] wmask(input logic [8:0] a);
        case (a[8:2])
            OFS_BANK[8:2]: return MSK_BANK;
            OFS_REFCLK[8:2]: return MSK_REFCLK;
            OFS_PLLRST[8:2]: return MSK_PLLRST;
            OFS_TXINIT[8:2]: return MSK_TXINIT;
            OFS_RXINIT[8:2]: return MSK_RXINIT;
            OFS_BUFCTRL[8:2]: return MSK_BUFCTRL;
            OFS_PWRDN[8:2]: return MSK_PWRDN;
            OFS_LOOP[8:2]: return MSK_LOOP;
            default: return RST_ZERO;
        endcase
    endfunction
    // expected read word from shadow and the transceiver stand-in
    function automatic logic [31:0] exp_rd(input logic [8:0] a);
        logic [31:0] ts, rs;
        logic [3:0] lk;
        for (int i = 0; i < NUM_CH; i++) begin
            lk[i] = !sh[5][0] && !sh[12][8*i];
            ts[8*i +: 8] = {5'h0, power_ok[i], !sh[7][8*i+1], !sh[7][8*i]};
            rs[8*i +: 8] = {5'h0, power_ok[i], !sh[9][8*i+1], !sh[9][8*i]};
        end
        case (a[8:2])
            OFS_VERSION[8:2]: return VER;
            OFS_PLLLOCK[8:2]: return {26'h0, !sh[5][2], !sh[5][1], lk};
            OFS_TXSTAT[8:2]: return ts;
            OFS_RXSTAT[8:2]: return rs;
            default: return sh[a[5:2]] & wmask(a);
        endcase
    endfunction
    task automatic wr(input logic [8:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] m;
        m = wmask(a) & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        @(negedge ref_clk);
        axi_req.awaddr = a;
        axi_req.wdata = d;
        axi_req.wstrb = s;
        axi_req.awvalid = 1'b1;
        axi_req.bready = 1'b1;
        // optionally hand over the address a cycle ahead of the data
        if (split) begin
            @(posedge ref_clk iff axi_rsp.awready);
            @(negedge ref_clk);
            axi_req.awvalid = 1'b0;
        end
        axi_req.wvalid = 1'b1;
        @(posedge ref_clk iff (axi_rsp.wready && (split || axi_rsp.awready)));
        @(negedge ref_clk);
        axi_req.awvalid = 1'b0;
        axi_req.wvalid = 1'b0;
        axi_req.wdata = ~d;
        @(posedge ref_clk iff axi_rsp.bvalid);
        chk("bresp", 32'(axi_rsp.bresp), 32'(RESP_OKAY));
        sh[a[5:2]] = (sh[a[5:2]] & ~m) | (d & m);
        @(negedge ref_clk);
        axi_req.bready = 1'b0;
    endtask
    task automatic rd_chk(input logic [8:0] a, input int slow);
        @(negedge ref_clk);
        axi_req.araddr = a;
        axi_req.arvalid = 1'b1;
        @(posedge ref_clk iff axi_rsp.arready);
        @(negedge ref_clk);
        axi_req.arvalid = 1'b0;
        axi_req.araddr = ~a;
        repeat (slow) @(negedge ref_clk);
        axi_req.rready = 1'b1;
        @(posedge ref_clk iff axi_rsp.rvalid);
        chk("rdata", axi_rsp.rdata, exp_rd(a));
        @(negedge ref_clk);
        axi_req.rready = 1'b0;
    endtask
    task automatic chk_ports;
        logic [7:0] t, r, p, l;
        chk("tx_bank", 32'(tx_bank), 32'(sh[3][4:0]));
        chk("rx_bank", 32'(rx_bank), 32'(sh[3][12:8]));
        chk("clk_sel", 32'(clk_sel), {12'h0, sh[4][3:0], sh[4][7:4], sh[4][11:8],
            sh[4][27:24], sh[4][31:28]});
        chk("pll_rst", {29'h0, quad_pll1_reset, quad_pll0_reset, chan_pll_reset}, sh[5]);
        chk("buf_dis", {30'h0, refclk1_buffer_disable, refclk0_buffer_disable}, sh[11]);
        for (int i = 0; i < NUM_CH; i++) begin
            t = sh[7][8*i +: 8];
            r = sh[9][8*i +: 8];
            p = sh[12][8*i +: 8];
            l = sh[14][8*i +: 8];
            chk("tx_ctl", 32'(tx_ctl[i]), 32'({t[0], t[1], t[2], t[3], t[7]}));
            chk("rx_ctl", 32'(rx_ctl[i]), 32'({r[0], r[1], r[2], r[3], r[4], r[5], r[6], r[7]}));
            chk("pwr_dn", 32'(pwr_dn[i]), 32'({p[0], p[1], p[2], p[4:3], p[6:5]}));
            chk("loop", 32'(loopback_mode[i]), 32'(l[2:0]));
        end
    endtask
    // main sequence: reset map, corners, random traffic, second reset
    initial begin
        logic [8:0] a;
        for (int k = 0; k < 16; k++) sh[k] = '0;
        repeat (10) @(negedge ref_clk);
        nrst = 1'b1;
        power_ok = 4'hA;
        for (int k = 0; k < 17; k++) rd_chk(9'(4*k), k % 3);
        chk_ports();
        wr(OFS_BANK, 32'hFFFF_FFFF, 4'hF);
        wr(OFS_BUFCTRL, 32'hFFFF_FFFF, 4'hF);
        wr(OFS_PLLRST, 32'hFFFF_FFFF, 4'hF);
        wr(OFS_VERSION, 32'hFFFF_FFFF, 4'hF);
        for (int k = 0; k < 60; k++) begin
            a = 9'($random(seed)) & 9'h07F;
            power_ok = 4'($random(seed));
            rx_video_clk_stable = 1'($random(seed));
            rx_status_sb_tready = 1'($random(seed));
            axi_req.awprot = 3'($random(seed));
            split = 1'($random(seed));
            wr(a, $random(seed), (k % 4 == 0) ? 4'hF : 4'($random(seed)));
            repeat (4) @(negedge ref_clk);
            chk_ports();
            chk("sideband", {29'h0, rx_status_sb_tvalid, rx_status_sb_tdata},
                {30'h1, rx_video_clk_stable, !sh[9][0]});
            rd_chk((k % 2 == 0) ? a : 9'($random(seed)) & 9'h07F, k % 3);
        end
        @(negedge ref_clk);
        nrst = 1'b0;
        for (int k = 0; k < 16; k++) sh[k] = '0;
        repeat (10) @(negedge ref_clk);
        nrst = 1'b1;
        chk_ports();
        rd_chk(OFS_RXINIT, 1);
        final_report();
    end
    // watchdog well past the expected run length
    initial begin
        #400000;
        err_count++;
        final_report();
    end
endmodule

// *** verification/tpcr_regs_properties.sv ***
// checker: bus answers, bank and pll writes, status sideband
`timescale 1ns/100ps
module tpcr_regs_checker (
    input wire logic ref_clk, // bus clock
    input wire logic nrst, // reset, low
    input wire tpcr_pkg::tpcr_axi_req_s axi_req, // request
    input wire tpcr_pkg::tpcr_axi_rsp_s axi_rsp, // response
    input wire logic [4:0] tx_bank, // tx bank
    input wire logic [4:0] rx_bank, // rx bank
    input wire logic chan_pll_reset, // pll reset
    input wire tpcr_pkg::tpcr_stat_s [3:0] rx_stat, // rx status
    input wire logic rx_video_clk_stable, // video ok
    input wire logic [1:0] rx_status_sb_tdata, // sideband
    input wire logic rx_status_sb_tvalid // sideband valid
);
    import tpcr_pkg::*;
    logic [31:0] wd_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // write data seen at the previous edge
    always_ff @(posedge ref_clk) begin
        wd_q <= axi_req.wdata;
    end
    sequence s_wr;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence s_wr_full(logic [8:0] ofs);
        s_wr ##0 (axi_req.awaddr[8:2] == ofs[8:2] && axi_req.wstrb == 4'hF);
    endsequence
    a_write_okay: assert property (
        s_wr |=> axi_rsp.bvalid && axi_rsp.bresp == RESP_OKAY)
        else $error("write not answered okay");
    a_read_next: assert property (
        axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && axi_rsp.rresp == RESP_OKAY)
        else $error("read not answered okay");
    a_read_holds: assert property (
        axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read data dropped before taken");
    a_bank_update: assert property (
        s_wr_full(OFS_BANK) |=> tx_bank == wd_q[4:0] && rx_bank == wd_q[12:8])
        else $error("bank outputs wrong after write");
    a_pll_reset_bit: assert property (
        s_wr_full(OFS_PLLRST) |=> chan_pll_reset == wd_q[0])
        else $error("channel pll reset wrong after write");
    a_link_ready: assert property (
        rx_stat[0].reset_done [*4] |-> rx_status_sb_tdata[0])
        else $error("link ready not shown");
    a_link_idle: assert property (
        !rx_stat[0].reset_done [*4] |-> !rx_status_sb_tdata[0])
        else $error("link ready shown too early");
    a_video_ready: assert property (
        rx_video_clk_stable [*4] |-> rx_status_sb_tdata[1])
        else $error("video ready not shown");
    a_video_idle: assert property (
        !rx_video_clk_stable [*4] |-> !rx_status_sb_tdata[1])
        else $error("video ready shown too early");
    a_sb_valid: assert property (
        rx_status_sb_tvalid)
        else $error("sideband valid low");
endmodule
bind tpcr_regs tpcr_regs_checker i_checker (
    .ref_clk, .nrst, .axi_req, .axi_rsp, .tx_bank, .rx_bank, .chan_pll_reset,
    .rx_stat, .rx_video_clk_stable, .rx_status_sb_tdata, .rx_status_sb_tvalid
);

// *** verification/tpcr_xcvr_model.sv ***
// transceiver stand-in: locks and reset-done follow the controls
`timescale 1ns/100ps
module tpcr_xcvr_model (
    input wire logic ref_clk, // bus clock
    input wire logic chan_pll_reset, // pll reset
    input wire logic quad_pll0_reset, // quad0 reset
    input wire logic quad_pll1_reset, // quad1 reset
    input wire tpcr_pkg::tpcr_tx_ctl_s [3:0] tx_ctl, // tx controls
    input wire tpcr_pkg::tpcr_rx_ctl_s [3:0] rx_ctl, // rx controls
    input wire tpcr_pkg::tpcr_pd_s [3:0] pwr_dn, // power downs
    input wire logic [3:0] power_ok, // power good
    output logic [3:0] chan_pll_locked, // channel locks
    output logic quad_pll0_locked, // quad0 lock
    output logic quad_pll1_locked, // quad1 lock
    output tpcr_pkg::tpcr_stat_s [3:0] tx_stat, // tx status
    output tpcr_pkg::tpcr_stat_s [3:0] rx_stat // rx status
);
    import tpcr_pkg::*;
    // status lags the controls by a cycle, registered on the bus clock ref_clk
    always_ff @(posedge ref_clk) begin
        quad_pll0_locked <= !quad_pll0_reset;
        quad_pll1_locked <= !quad_pll1_reset;
        for (int i = 0; i < NUM_CH; i++) begin
            chan_pll_locked[i] <= !chan_pll_reset && !pwr_dn[i].chan_pll_power_down;
            tx_stat[i] <= {!tx_ctl[i].xcvr_tx_reset, !tx_ctl[i].tx_analog_reset, power_ok[i]};
            rx_stat[i] <= {!rx_ctl[i].xcvr_rx_reset, !rx_ctl[i].rx_analog_reset, power_ok[i]};
        end
    end
endmodule
